// file: hw/hpdm_pkg.sv
// Package of constants for the high port data and mode block.
package hpdm_pkg;

  // ****************************************
  // Special-function register addresses
  // ****************************************
  localparam logic [7:0] HPDM_ADDR_P5_MODE  = 8'h9D;
  localparam logic [7:0] HPDM_ADDR_P5_LATCH = 8'hD8;
  localparam logic [7:0] HPDM_ADDR_P6_LATCH = 8'hE8;
  localparam logic [7:0] HPDM_ADDR_P6_MODE  = 8'h9E;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] HPDM_RST_LATCH = 8'hFF;
  localparam logic [7:0] HPDM_RST_MODE  = 8'h00;

endpackage : hpdm_pkg

// file: hw/hpdm_pin_if.sv
// Interface carrying one byte-wide port's driver controls and sensed levels.
interface hpdm_pin_if #(parameter int W = 8);
  logic [W-1:0] latch;
  logic [W-1:0] mode;
  logic [W-1:0] ovr_en;
  logic [W-1:0] ovr_val;
  logic [W-1:0] pin_sync;
  logic [W-1:0] pin_o;
  logic [W-1:0] pin_oe_n;
  logic [W-1:0] pullup_en;
  modport ctrl (output latch, mode, ovr_en, ovr_val, input pin_sync);
  modport drv  (input latch, mode, ovr_en, ovr_val, output pin_o, pin_oe_n, pullup_en);
endinterface : hpdm_pin_if

// file: hw/hpdm_pin_drv.sv
// Per-pin output driver for one byte-wide port.
module hpdm_pin_drv (
  hpdm_pin_if.drv p
);
  // One driver per pin; the memory interface overrides the latch value only.
  for (genvar i = 0; i < 8; i++) begin : g_pin
    logic val;
    assign val = p.ovr_en[i] ? p.ovr_val[i] : p.latch[i];
    assign p.pin_o[i] = val;
    // Open-drain releases a high; push-pull drives both levels.
    assign p.pin_oe_n[i] = ~(~val | p.mode[i]);
    assign p.pullup_en[i] = val | ~p.pin_oe_n[i] ? val : 1'b1;
  end
endmodule : hpdm_pin_drv

// file: hw/hpdm_top.sv
// Port five and six latches, drive modes, memory override and pin readback.
// Summary of operation
// - Latch bit drives pin level
// - Register read returns sensed pin level
// - Open-drain latch one releases the pin
// - Mode zero selects open-drain driver
// - Mode one selects push-pull driver
// - Port five carries upper address byte
// - Read-modify-write reads latch contents
// - Reset clears all drive modes
// - Memory move controls pin outputs
// - Pullup off while pin driven low
module hpdm_top
  import hpdm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_rmw,
  output logic      [7:0] sfr_rdata,
  // External memory bus override
  input  wire logic       ext_move_active,
  input  wire logic [15:0] ext_addr,
  // Port five pins
  input  wire logic [7:0] p5_pin_i,
  output logic      [7:0] p5_pin_o,
  output logic      [7:0] p5_pin_oe_n,
  output logic      [7:0] p5_pullup_en,
  // Port six pins
  input  wire logic [7:0] p6_pin_i,
  output logic      [7:0] p6_pin_o,
  output logic      [7:0] p6_pin_oe_n,
  output logic      [7:0] p6_pullup_en
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] port_five_latch_r;
  logic [7:0] port_six_latch_r;
  logic [7:0] port_five_drive_mode_r;
  logic [7:0] port_six_drive_mode_r;
  logic [7:0] p5_meta_r, p5_sync_r, p6_meta_r, p6_sync_r;
  logic [7:0] rdata_nxt;

  hpdm_pin_if p5 ();
  hpdm_pin_if p6 ();

  // Latch writes land on the next edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      port_five_latch_r <= HPDM_RST_LATCH;
      port_six_latch_r  <= HPDM_RST_LATCH;
    end else if (sfr_wr) begin
      if (sfr_addr == HPDM_ADDR_P5_LATCH) port_five_latch_r <= sfr_wdata;
      if (sfr_addr == HPDM_ADDR_P6_LATCH) port_six_latch_r <= sfr_wdata;
    end
  end

  // Drive modes come up open-drain so nothing fights the board at power-up.
  always_ff @(posedge clk) begin
    if (rst) begin
      port_five_drive_mode_r <= HPDM_RST_MODE;
      port_six_drive_mode_r  <= HPDM_RST_MODE;
    end else if (sfr_wr) begin
      if (sfr_addr == HPDM_ADDR_P5_MODE) port_five_drive_mode_r <= sfr_wdata;
      if (sfr_addr == HPDM_ADDR_P6_MODE) port_six_drive_mode_r <= sfr_wdata;
    end
  end

  // Pins are asynchronous; two flops before anything reads them.
  always_ff @(posedge clk) begin
    if (rst) begin
      p5_meta_r <= 8'h00;
      p5_sync_r <= 8'h00;
      p6_meta_r <= 8'h00;
      p6_sync_r <= 8'h00;
    end else begin
      p5_meta_r <= p5_pin_i;
      p5_sync_r <= p5_meta_r;
      p6_meta_r <= p6_pin_i;
      p6_sync_r <= p6_meta_r;
    end
  end

  // Read mux; a read-modify-write sees the latch so untouched bits are not corrupted.
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (sfr_addr)
      HPDM_ADDR_P5_LATCH: rdata_nxt = sfr_rmw ? port_five_latch_r : p5_sync_r;
      HPDM_ADDR_P6_LATCH: rdata_nxt = sfr_rmw ? port_six_latch_r : p6_sync_r;
      HPDM_ADDR_P5_MODE:  rdata_nxt = port_five_drive_mode_r;
      HPDM_ADDR_P6_MODE:  rdata_nxt = port_six_drive_mode_r;
      default:            rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered one cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) sfr_rdata <= 8'h00;
    else if (sfr_rd) sfr_rdata <= rdata_nxt;
  end

  // ****************************************
  // Driver hookup
  // ****************************************
  assign p5.latch    = port_five_latch_r;
  assign p5.mode     = port_five_drive_mode_r;
  assign p5.ovr_en   = {8{ext_move_active}};
  assign p5.ovr_val  = ext_addr[15:8];
  assign p5.pin_sync = p5_sync_r;
  assign p6.latch    = port_six_latch_r;
  assign p6.mode     = port_six_drive_mode_r;
  assign p6.ovr_en   = {8{ext_move_active}};
  assign p6.ovr_val  = ext_addr[7:0];
  assign p6.pin_sync = p6_sync_r;

  hpdm_pin_drv u_p5 (.p(p5.drv));
  hpdm_pin_drv u_p6 (.p(p6.drv));

  assign p5_pin_o     = p5.pin_o;
  assign p5_pin_oe_n  = p5.pin_oe_n;
  assign p5_pullup_en = p5.pullup_en;
  assign p6_pin_o     = p6.pin_o;
  assign p6_pin_oe_n  = p6.pin_oe_n;
  assign p6_pullup_en = p6.pullup_en;

  // ****************************************
  // Assertions
  // ****************************************
  mode_reset_a: assert property (@(posedge clk) $fell(rst) |-> port_five_drive_mode_r == 8'h00)
    else $error("drive mode not cleared by reset");
  latch_write_a: assert property (@(posedge clk) disable iff (rst)
    sfr_wr && sfr_addr == HPDM_ADDR_P5_LATCH |=> port_five_latch_r == $past(sfr_wdata))
    else $error("latch write lost");
  pin_read_a: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && !sfr_rmw && sfr_addr == HPDM_ADDR_P5_LATCH |=> sfr_rdata == $past(p5_sync_r))
    else $error("read did not return pin level");
  rmw_read_a: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && sfr_rmw && sfr_addr == HPDM_ADDR_P6_LATCH |=> sfr_rdata == $past(port_six_latch_r))
    else $error("rmw read did not return latch");
  od_release_a: assert property (@(posedge clk) disable iff (rst)
    !ext_move_active |-> (p5_pin_oe_n == (port_five_latch_r & ~port_five_drive_mode_r)))
    else $error("open-drain release wrong");
  pp_drive_a: assert property (@(posedge clk) disable iff (rst)
    (p6_pin_oe_n & port_six_drive_mode_r) == 8'h00)
    else $error("push-pull pin not driven");
  od_low_a: assert property (@(posedge clk) disable iff (rst)
    ((~p5_pin_o) & p5_pin_oe_n) == 8'h00)
    else $error("open-drain low not driven");
  ext_addr_a: assert property (@(posedge clk) disable iff (rst)
    ext_move_active |-> p5_pin_o == ext_addr[15:8] && p6_pin_o == ext_addr[7:0])
    else $error("address byte not on pins");
  pullup_off_a: assert property (@(posedge clk) disable iff (rst)
    ((~p6_pin_o) & ~p6_pin_oe_n & p6_pullup_en) == 8'h00)
    else $error("pullup on while driving low");

  // ****************************************
  // Register access sequences
  // ****************************************
  // A write strobe aimed at the port five drive mode register.
  sequence p5_mode_wr_s;
    sfr_wr && sfr_addr == HPDM_ADDR_P5_MODE;
  endsequence

  // A write strobe aimed at the port six drive mode register.
  sequence p6_mode_wr_s;
    sfr_wr && sfr_addr == HPDM_ADDR_P6_MODE;
  endsequence

  // A write strobe aimed at the port six output latch.
  sequence p6_latch_wr_s;
    sfr_wr && sfr_addr == HPDM_ADDR_P6_LATCH;
  endsequence

  // A read strobe at an address that no register of this block answers.
  sequence unmapped_rd_s;
    sfr_rd && sfr_addr != HPDM_ADDR_P5_LATCH && sfr_addr != HPDM_ADDR_P6_LATCH &&
      sfr_addr != HPDM_ADDR_P5_MODE && sfr_addr != HPDM_ADDR_P6_MODE;
  endsequence

  // ****************************************
  // Register access assertions
  // ****************************************
  // A mode write must take effect on the next edge, or the driver keeps the old configuration.
  mode5_write_a: assert property (@(posedge clk) disable iff (rst)
    p5_mode_wr_s |=> port_five_drive_mode_r == $past(sfr_wdata))
    else $error("port five mode write lost");

  // The same holds for the port six mode register.
  mode6_write_a: assert property (@(posedge clk) disable iff (rst)
    p6_mode_wr_s |=> port_six_drive_mode_r == $past(sfr_wdata))
    else $error("port six mode write lost");

  // Port six latch writes land just as port five ones do.
  latch6_write_a: assert property (@(posedge clk) disable iff (rst)
    p6_latch_wr_s |=> port_six_latch_r == $past(sfr_wdata))
    else $error("port six latch write lost");

  // Unmapped reads return zero so software never sees stale bytes.
  unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
    unmapped_rd_s |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Read data holds between strobes; software may sample it late.
  rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  // ****************************************
  // Pin assertions
  // ****************************************
  // The low address byte must sit on port six during a memory move.
  ext_low_byte_a: assert property (@(posedge clk) disable iff (rst)
    ext_move_active |-> p6_pin_o == ext_addr[7:0])
    else $error("low address byte not on pins");

  // Port five must not fight its own pullup either.
  pullup_p5_a: assert property (@(posedge clk) disable iff (rst)
    ((~p5_pin_o) & ~p5_pin_oe_n & p5_pullup_en) == 8'h00)
    else $error("port five pullup on while driving low");

  // Outside a memory move, the port six pins follow the latch exactly.
  latch_drive_a: assert property (@(posedge clk) disable iff (rst)
    !ext_move_active |-> p6_pin_o == port_six_latch_r)
    else $error("pin value does not follow latch");

endmodule : hpdm_top

// file: testbench/test_high_port_data_and_mode.sv
// Self-checking bench for the port five and six latch, drive mode and override block.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_high_port_data_and_mode;
  timeunit 1ns;
  timeprecision 1ns;
  import hpdm_pkg::*;

  typedef struct packed {logic [7:0] l5; logic [7:0] m5; logic [7:0] l6; logic [7:0] m6;} hpdm_row_t;

  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, ext_move_active = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, p5_pin_i = 8'h00, p6_pin_i = 8'h00;
  logic [7:0]  sfr_rdata, p5_pin_o, p5_pin_oe_n, p5_pullup_en, p6_pin_o, p6_pin_oe_n, p6_pullup_en;
  logic [15:0] ext_addr = 16'h0000;
  int          fail_count = 0, checked = 0;
  hpdm_row_t   rows [4] = '{'{8'h00, 8'h00, 8'hFF, 8'h00}, '{8'hA5, 8'h0F, 8'h5A, 8'hF0},
                           '{8'hFF, 8'hFF, 8'h00, 8'hFF}, '{8'hFF, 8'hFF, 8'hFF, 8'hFF}};

  // A 50 MHz clock.
  always #10 clk = ~clk;

  hpdm_top dut_u (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .ext_move_active(ext_move_active),
    .ext_addr(ext_addr), .p5_pin_i(p5_pin_i), .p5_pin_o(p5_pin_o), .p5_pin_oe_n(p5_pin_oe_n),
    .p5_pullup_en(p5_pullup_en), .p6_pin_i(p6_pin_i), .p6_pin_o(p6_pin_o), .p6_pin_oe_n(p6_pin_oe_n),
    .p6_pullup_en(p6_pullup_en));

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  // Writes are driven at the falling edge so the rising edge sees stable inputs.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is sampled one falling edge after the strobe.
  task automatic rdchk(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rmw = m;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    `CHK(sfr_rdata, e)
  endtask : rdchk

  // A released pin shows only through its enable, so the drive value is judged with it.
  task automatic chk_port(input logic [7:0] v, m, o, oe, pu);
    `CHK(o, v)
    `CHK(oe, v & ~m)
    `CHK(pu & ~v, 8'h00)
  endtask : chk_port

  task automatic give_verdict;
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk_port(8'hFF, 8'h00, p5_pin_o, p5_pin_oe_n, p5_pullup_en);
    rdchk(HPDM_ADDR_P5_MODE, 1'b0, 8'h00);
    rdchk(HPDM_ADDR_P6_MODE, 1'b0, 8'h00);
    rdchk(HPDM_ADDR_P6_LATCH, 1'b1, 8'hFF);
    foreach (rows[i]) begin
      wr(HPDM_ADDR_P5_LATCH, rows[i].l5);
      wr(HPDM_ADDR_P5_MODE, rows[i].m5);
      wr(HPDM_ADDR_P6_LATCH, rows[i].l6);
      wr(HPDM_ADDR_P6_MODE, rows[i].m6);
      chk_port(rows[i].l5, rows[i].m5, p5_pin_o, p5_pin_oe_n, p5_pullup_en);
      chk_port(rows[i].l6, rows[i].m6, p6_pin_o, p6_pin_oe_n, p6_pullup_en);
    end
    // Pins differ from latches, so a latch read cannot pass for a pin read.
    wr(HPDM_ADDR_P5_LATCH, 8'h0F);
    p5_pin_i = 8'h96;
    p6_pin_i = 8'h69;
    repeat (4) @(negedge clk);
    rdchk(HPDM_ADDR_P5_LATCH, 1'b0, 8'h96);
    rdchk(HPDM_ADDR_P5_LATCH, 1'b1, 8'h0F);
    rdchk(HPDM_ADDR_P6_LATCH, 1'b0, 8'h69);
    rdchk(8'h11, 1'b0, 8'h00);
    wr(8'h11, 8'h00);
    chk_port(8'h0F, 8'hFF, p5_pin_o, p5_pin_oe_n, p5_pullup_en);
    // Override while port five is half open-drain.
    wr(HPDM_ADDR_P5_MODE, 8'h0F);
    ext_addr = 16'h3CC3;
    ext_move_active = 1'b1;
    @(negedge clk);
    chk_port(8'h3C, 8'h0F, p5_pin_o, p5_pin_oe_n, p5_pullup_en);
    chk_port(8'hC3, 8'hFF, p6_pin_o, p6_pin_oe_n, p6_pullup_en);
    ext_move_active = 1'b0;
    @(negedge clk);
    chk_port(8'h0F, 8'h0F, p5_pin_o, p5_pin_oe_n, p5_pullup_en);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk_port(8'hFF, 8'h00, p6_pin_o, p6_pin_oe_n, p6_pullup_en);
    give_verdict();
  end

  // The sequence needs under a hundred cycles; two thousand means a hang.
  initial begin
    #(2000 * 20);
    fail_count++;
    give_verdict();
  end
endmodule : test_high_port_data_and_mode
